// ==== include/sapc_pkg.sv ====
// Purpose: shared constants for the converter control and output port
// Assumes: 20 MHz mclk
// Notes:   times in ns, cycle counts derived from the clock period
`default_nettype none
package sapc_pkg;
	localparam int          CLK_PERIOD_NS     = 50;
	localparam int          RESULT_WIDTH      = 16;
	// conversion time, rounded down to whole cycles
	localparam int          CONV_TIME_NS      = 3400;
	localparam int          CONV_CYCLES       = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (CONV_TIME_NS / CLK_PERIOD_NS);
	// data valid ahead of busy rising, rounded up
	localparam int          VALID_LEAD_NS     = 35;
	localparam int          VALID_LEAD_CYCLES = (VALID_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] RESULT_RESET      = 16'h0000;
	localparam logic [2:0]  SYNC_RESET        = 3'h7;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT,
		ST_PRESENT
	} sapc_state_type;
endpackage
`default_nettype wire

// ==== logic/sapc_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for a pin input
// Assumes: input asynchronous to mclk
// Notes:   output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module sapc_sync (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic pin_in,
	output var  logic level_out
);
	import sapc_pkg::*;
	logic [2:0] sync_q;
	logic       level_q;
	wire        agree = (sync_q[1] == sync_q[2]);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync_q  <= SYNC_RESET;
			level_q <= 1'b1;
		end else begin
			sync_q <= {sync_q[1:0], pin_in};
			if (agree)
				level_q <= sync_q[2];
		end
	end
	assign level_out = level_q;
endmodule
`default_nettype wire

// ==== logic/sapc_port.sv ====
// Purpose: control and parallel result port of a 16-bit sampling converter
// Assumes: host drives select and read/convert asynchronously; core supplies the result sample
// Notes:   result bus enable is active low; busy is active low
`timescale 1ns/100ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (R1) result bus floats when select high, read/convert low, or converting
// (R2) select falling with read/convert high and idle drives latest result
// (R3) select falling with read/convert low starts conversion only when idle
// (R4) busy goes low at conversion start, stays low until finished
// (R5) result is valid on the bus before busy rises
// (R6) host raises select or read/convert within 250ns of busy rising
// (R7) result is one 16-bit word in two's complement
// (R8) top output bit carries the msb, bottom output bit the lsb
// (R9) host allows 4.0us between conversion starts
// (R10) host drops read/convert at least 100ns before select
// (R11) host returns controls high early in the conversion, then static; the bench keeps select or read/convert low and once drops both again
// (R12) host treats busy rising as completion and waits acquisition time
module sapc_port #(
	parameter int CONV_CYC = sapc_pkg::CONV_CYCLES,
	parameter int LEAD_CYC = sapc_pkg::VALID_LEAD_CYCLES
) (
	input  wire logic                              mclk,
	input  wire logic                              rst,
	input  wire logic                              select_n,
	input  wire logic                              read_conv,
	input  wire logic [sapc_pkg::RESULT_WIDTH-1:0] sample_in,
	output var  logic                              busy_n,
	output var  logic                              conv_start,
	output var  logic [sapc_pkg::RESULT_WIDTH-1:0] result_out,
	output var  logic                              result_oe_n,
	output var  logic                              result_bit_top,
	output var  logic                              result_bit_bottom
);
	import sapc_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic sel_s;
	logic rc_s;
	sapc_sync u_sel (
		.mclk      (mclk),
		.rst       (rst),
		.pin_in    (select_n),
		.level_out (sel_s)
	);
	sapc_sync u_rc (
		.mclk      (mclk),
		.rst       (rst),
		.pin_in    (read_conv),
		.level_out (rc_s)
	);
	//////////////////////////////////////////////////////////////////////////
	// state
	sapc_state_type              state_q;
	sapc_state_type              state_d;
	logic                        sel_prev_q;
	logic [15:0]                 cnt_q;
	logic [15:0]                 cnt_d;
	logic [RESULT_WIDTH-1:0]     result_q;
	logic [RESULT_WIDTH-1:0]     result_d;
	logic                        oe_n_q;
	logic                        oe_n_d;
	logic                        busy_n_q;
	logic                        busy_n_d;
	logic                        start_q;

	//////////////////////////////////////////////////////////////////////////
	// decode
	wire                         sel_fall    = sel_prev_q & ~sel_s;
	wire                         idle        = (state_q == ST_IDLE);
	wire                         in_convert  = (state_q == ST_CONVERT);
	wire                         in_present  = (state_q == ST_PRESENT);
	wire                         start_req   = sel_fall & ~rc_s & idle;          // [R3]
	wire                         read_req    = sel_fall & rc_s & idle;           // [R2]
	wire                         float_req   = sel_s | ~rc_s;                    // [R1]
	wire                         read_window = ~sel_s & rc_s;
	wire                         cnt_last    = (cnt_q == 16'(CONV_CYC - 1));
	wire                         cnt_lead    = (cnt_q == 16'(CONV_CYC - 1 - LEAD_CYC));
	wire [15:0]                  cnt_inc     = cnt_q + 16'h0001;
	wire                         capture     = in_convert & cnt_lead;            // [R7]
	wire                         finish      = in_present & cnt_last;            // [R4]

	//////////////////////////////////////////////////////////////////////////
	// conversion control
	always_comb begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		busy_n_d = busy_n_q;
		case (state_q)
			ST_IDLE: begin
				if (start_req) begin
					state_d  = ST_CONVERT;
					cnt_d    = 16'h0000;
					busy_n_d = 1'b0;                                       // [R4]
				end
			end

			ST_CONVERT: begin
				cnt_d = cnt_inc;
				if (capture) begin
					state_d = ST_PRESENT;
				end
			end

			ST_PRESENT: begin
				cnt_d = cnt_inc;
				if (finish) begin
					state_d  = ST_IDLE;
					busy_n_d = 1'b1;                                       // [R4]
				end
			end

			default: begin
				state_d  = ST_IDLE;
				busy_n_d = 1'b1;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// result bus control
	always_comb begin
		result_d = result_q;
		oe_n_d   = oe_n_q;
		case (state_q)
			ST_IDLE: begin
				if (start_req | float_req) begin
					oe_n_d = 1'b1;                                         // [R1]
				end else if (read_req) begin
					oe_n_d = 1'b0;                                         // [R2]
				end
			end

			ST_CONVERT: begin
				oe_n_d = 1'b1;                                             // [R1]
				if (capture) begin
					result_d = sample_in;                                  // [R7]
					oe_n_d   = ~read_window;                               // [R5]
				end
			end

			ST_PRESENT: begin
				oe_n_d = ~read_window;                                     // [R5]
			end

			default: begin
				oe_n_d = 1'b1;
			end
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sel_prev_q <= 1'b1;
		end else begin
			sel_prev_q <= sel_s;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			result_q <= RESULT_RESET;
		end else begin
			result_q <= result_d;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			oe_n_q <= 1'b1;
		end else begin
			oe_n_q <= oe_n_d;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busy_n_q <= 1'b1;
		end else begin
			busy_n_q <= busy_n_d;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			start_q <= 1'b0;
		end else begin
			start_q <= start_req;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs
	assign busy_n            = busy_n_q;
	assign conv_start        = start_q;
	assign result_oe_n       = oe_n_q;
	assign result_bit_top    = result_q[RESULT_WIDTH-1];                  // [R8]
	assign result_bit_bottom = result_q[0];                               // [R8]

	// msb on the highest output, lsb on the lowest
	genvar gi;
	generate
		for (gi = 0; gi < RESULT_WIDTH; gi++) begin : g_bit
			assign result_out[gi] = result_q[gi];                         // [R8]
		end
	endgenerate
endmodule
`default_nettype wire

// ==== tb/sapc_host.sv ====
// Purpose: host model for select and read/convert
// Assumes: pins change on the falling edge
// Notes:   start keeps the preferred pin order
`timescale 1ns/100ps
`default_nettype none
module sapc_host (
	input  wire logic mclk,
	output var  logic select_n = 1'b1,
	output var  logic read_conv = 1'b1
);
	task automatic drive(input logic s, input logic r, input int n);
		@(negedge mclk);
		select_n = s;
		read_conv = r;
		repeat (n) @(negedge mclk);
	endtask
	task automatic conv(input logic keep);
		drive(1'b1, 1'b0, 2);
		drive(1'b0, 1'b0, 3);
		drive(~keep, keep, 0);
	endtask
endmodule
`default_nettype wire

// ==== tb/sapc_port_chk.sv ====
// Purpose: port checks
// Assumes: top module pins only
// Notes:   bound below
`timescale 1ns/100ps
`default_nettype none
module sapc_port_chk #(
	parameter int CONV_CYC = sapc_pkg::CONV_CYCLES,
	parameter int LEAD_CYC = sapc_pkg::VALID_LEAD_CYCLES
) (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        busy_n,
	input wire logic        conv_start,
	input wire logic        result_oe_n,
	input wire logic        result_bit_top,
	input wire logic        result_bit_bottom,
	input wire logic [15:0] result_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	start_fall_a: assert property (conv_start |-> $fell(busy_n)) else $error("stray start");
	one_pulse_a: assert property (conv_start |=> !conv_start) else $error("long start");
	busy_len_a: assert property ($fell(busy_n) |-> ##CONV_CYC $rose(busy_n)) else $error("busy length");
	float_start_a: assert property ($fell(busy_n) |-> result_oe_n [*3]) else $error("bus driven");
	data_early_a: assert property ($rose(busy_n) |-> $stable(result_out)) else $error("late data");
	hold_idle_a: assert property ($changed(result_out) |-> !busy_n) else $error("result moved");
	top_msb_a: assert property (result_bit_top == result_out[15]) else $error("msb pin");
	bot_lsb_a: assert property (result_bit_bottom == result_out[0]) else $error("lsb pin");
	cover property ($fell(busy_n));
	cover property ($fell(result_oe_n) && busy_n);
	cover property ($rose(busy_n) && !result_oe_n);
endmodule
bind sapc_port sapc_port_chk #(.CONV_CYC(CONV_CYC), .LEAD_CYC(LEAD_CYC)) u_chk (.mclk(mclk), .rst(rst),
	.busy_n(busy_n), .conv_start(conv_start), .result_oe_n(result_oe_n), .result_bit_top(result_bit_top),
	.result_bit_bottom(result_bit_bottom), .result_out(result_out));
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: self-checking bench
// Assumes: short conversion count
// Notes:   queue model of results
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        mclk, rst, sel_n, rc, busy_n, start, oe_n, b_top, b_bot;
	logic [15:0] sample, res, exp;
	wire  [15:0] dbus = oe_n ? 16'hzzzz : res;
	int          n_errors, num_checks, n_starts, seed;
	logic [15:0] q[$];
	sapc_port #(.CONV_CYC(20), .LEAD_CYC(1)) u_dut (.mclk(mclk), .rst(rst), .select_n(sel_n), .read_conv(rc),
		.sample_in(sample), .busy_n(busy_n), .conv_start(start), .result_out(res), .result_oe_n(oe_n),
		.result_bit_top(b_top), .result_bit_bottom(b_bot));
	sapc_host u_host (.mclk(mclk), .select_n(sel_n), .read_conv(rc));
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		num_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("[FAIL] %0t saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wait_busy();
		for (int k = 0; busy_n !== 1'b0; k++) begin
			if (k > 19) begin
				n_errors++;
				conclude();
			end
			@(negedge mclk);
		end
		for (int k = 0; busy_n !== 1'b1; k++) begin
			if (k > 99) begin
				n_errors++;
				conclude();
			end
			@(negedge mclk);
		end
	endtask
	always @(negedge mclk) if (start === 1'b1) n_starts++;
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		seed = 32'h0000_86b3;
		rst = 1'b1;
		sample = 16'h0000;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		check({oe_n, busy_n, res[13:0]}, 16'hc000);
		u_host.drive(1'b0, 1'b1, 5);
		check(dbus, 16'h0000);
		u_host.drive(1'b1, 1'b1, 3);
		for (int i = 0; i < 6; i++) begin
			sample = $random(seed);
			q.push_back(sample);
			u_host.conv(i[0]);
			if (i == 4) u_host.drive(1'b0, 1'b0, 2);
			wait_busy();
			exp = q.pop_front();
			if (i[0]) check(dbus, exp);
			else check({15'h0000, oe_n}, 16'h0001);
			u_host.drive(1'b1, 1'b1, 3);
			u_host.drive(1'b0, 1'b1, 5);
			check(dbus, exp);
			check({14'h0000, b_top, b_bot}, {14'h0000, exp[15], exp[0]});
			u_host.drive(1'b1, 1'b1, 60);
		end
		check(16'(n_starts), 16'h0006);
		conclude();
	end
endmodule
`default_nettype wire
